//--- logic/fan_limits_cfg.svh
`ifndef FAN_LIMITS_CFG_SVH
`define FAN_LIMITS_CFG_SVH
// ****************************************
// Register offsets
// ****************************************
`define OFS_OUT1_MIN_DUTY      8'h64
`define OFS_OUT2_MIN_DUTY      8'h65
`define OFS_OUT3_MIN_DUTY      8'h66
`define OFS_REMOTE1_START      8'h67
`define OFS_LOCAL_START        8'h68
`define OFS_REMOTE2_START      8'h69
`define OFS_REMOTE1_CRIT       8'h6a
`define OFS_LOCAL_CRIT         8'h6b
`define OFS_REMOTE2_CRIT       8'h6c
`define OFS_R1_LOCAL_HYST      8'h6d
`define OFS_REMOTE2_HYST       8'h6e
`define OFS_TEST_ENABLE        8'h6f
`define OFS_REMOTE1_OFFSET     8'h70
`define OFS_LOCAL_OFFSET       8'h71
// ****************************************
// Reset values and codes
// ****************************************
`define RST_MIN_DUTY           8'h80
`define RST_START_TEMP         8'h9a
`define RST_CRIT_LIMIT         8'ha4
`define RST_R1_LOCAL_HYST      8'h44
`define RST_REMOTE2_HYST       8'h40
`define RST_ZERO               8'h00
`define CRIT_DISABLE_CODE      8'h80
`define DUTY_FULL              8'hff
`define DUTY_OFF               8'h00
// ****************************************
// Field positions
// ****************************************
`define LOCAL_HYST_LSB         0
`define REMOTE1_HYST_LSB       4
`define REMOTE2_HYST_LSB       4
`define TEST_BIT_POS           0
`define DEG_PER_STEP_SHIFT     2
`endif

//--- logic/fan_limits_pkg.sv
`default_nettype none
package fan_limits_pkg;
    typedef enum logic [1:0] {CH_REMOTE1, CH_LOCAL, CH_REMOTE2} chan_e;
    // Temperature codes carry a 64 degree bias, one degree per step
    typedef logic [7:0] temp_t;
    typedef struct packed {
        logic [7:0] start_temp;
        logic [7:0] crit_limit;
        logic [3:0] hyst;
    } chan_cfg_s;
endpackage : fan_limits_pkg
`default_nettype wire

//--- logic/chan_limit_if.sv
`default_nettype none
interface chan_limit_if;
    import fan_limits_pkg::*;
    chan_cfg_s  cfg;
    logic [9:0] temp_q2;
    logic       sample;
    logic       fan_on;
    logic       crit_hot;
    logic       pin_hot;
    modport bank (output cfg, output temp_q2, output sample, input fan_on, input crit_hot, input pin_hot);
    modport chan (input cfg, input temp_q2, input sample, output fan_on, output crit_hot, output pin_hot);
endinterface : chan_limit_if
`default_nettype wire

//--- logic/chan_limit_eval.sv
`include "fan_limits_cfg.svh"
`default_nettype none
module chan_limit_eval
    import fan_limits_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst_b,
    chan_limit_if.chan  lim
);
    logic       fan_on_q,   fan_on_d;
    logic       crit_q,     crit_d;
    logic       pin_q,      pin_d;
    logic [9:0] start_q2, crit_q2, hyst_q2, start_rel, crit_rel;
    logic       crit_en;

    always_comb begin
        start_q2  = {lim.cfg.start_temp, 2'b00};
        crit_q2   = {lim.cfg.crit_limit, 2'b00};
        hyst_q2   = {4'h0, lim.cfg.hyst, 2'b00};
        start_rel = (start_q2 > hyst_q2) ? start_q2 - hyst_q2 : 10'h000;
        crit_rel  = (crit_q2 > hyst_q2) ? crit_q2 - hyst_q2 : 10'h000;
        crit_en   = (lim.cfg.crit_limit != `CRIT_DISABLE_CODE);
        fan_on_d  = fan_on_q;
        crit_d    = crit_q;
        pin_d     = pin_q;
        if (lim.sample) begin
            // Release needs the reading to drop to start minus hysteresis
            if (lim.temp_q2 > start_q2)
                fan_on_d = 1'b1;
            else if (lim.temp_q2 <= start_rel)
                fan_on_d = 1'b0;
            if (!crit_en)
                crit_d = 1'b0;
            else if (lim.temp_q2 > crit_q2)
                crit_d = 1'b1;
            else if (lim.temp_q2 < crit_rel)
                crit_d = 1'b0;
            // Pin trips one quarter degree above the limit
            pin_d = crit_en && (lim.temp_q2 >= crit_q2 + 10'h001);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fan_on_q <= 1'b0;
            crit_q   <= 1'b0;
            pin_q    <= 1'b0;
        end else begin
            fan_on_q <= fan_on_d;
            crit_q   <= crit_d;
            pin_q    <= pin_d;
        end
    end

    assign lim.fan_on   = fan_on_q;
    assign lim.crit_hot = crit_q;
    assign lim.pin_hot  = pin_q;
endmodule : chan_limit_eval
`default_nettype wire

//--- logic/duty_shaper.sv
`include "fan_limits_cfg.svh"
`default_nettype none
module duty_shaper
    import fan_limits_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [7:0] min_duty,
    input  wire logic       min_select,
    input  wire logic       fan_on,
    input  wire logic [7:0] span_duty,
    input  wire logic       force_full,
    output logic      [7:0] duty
);
    logic [7:0] duty_q, duty_d;

    always_comb begin
        if (force_full)
            duty_d = `DUTY_FULL;
        else if (fan_on)
            duty_d = (span_duty > min_duty) ? span_duty : min_duty;
        else
            duty_d = min_select ? min_duty : `DUTY_OFF;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            duty_q <= `DUTY_OFF;
        else
            duty_q <= duty_d;
    end

    assign duty = duty_q;
endmodule : duty_shaper
`default_nettype wire

//--- logic/fan_control_limit_registers.sv
// Function
// - Minimum duty code is linear: 00 off, 40 quarter, 80 half, ff full
// - Lock bit set makes the whole bank read-only; writes are dropped
// - Above start temperature the fan runs at least at minimum duty, rising over span
// - Any reading above its critical limit forces every output to full duty
// - Critical limit code 80 disables the full-speed fail-safe of that channel
// - Full duty holds until reading drops below critical limit minus hysteresis
// - Reading a quarter degree above critical limit drives overtemp pin low if enabled
// - Below start temperature the fan keeps minimum duty until start minus hysteresis
// - Hysteresis nibbles: local 3:0, remote1 7:4, remote2 7:4 of own register
// - Test bit 0 set enters logic-tree test mode; clearing leaves it
// - Signed offset, half degree per step, is added to each reading
// - One hysteresis value releases both start and critical conditions
// - Below start minus hysteresis each output goes off or minimum per select bit
// - Minimum duty registers are read-only in automatic fan mode
`include "fan_limits_cfg.svh"
`default_nettype none
module fan_control_limit_registers
    import fan_limits_pkg::*;
#(
    parameter int NUM_CHANNELS = 3
) (
    input  wire logic       SYS_CLK,
    input  wire logic       RST_B,
    input  wire logic       REG_WR,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    input  wire logic       CONFIG_LOCK,
    input  wire logic       AUTO_MODE,
    input  wire logic       OVERTEMP_PIN_OUT_EN,
    input  wire logic [2:0] MINIMUM_SELECT,
    input  wire logic       CONV_DONE,
    input  wire logic [7:0] REMOTE1_TEMP,
    input  wire logic [7:0] LOCAL_TEMP,
    input  wire logic [7:0] REMOTE2_TEMP,
    input  wire logic [7:0] REMOTE2_OFFSET,
    input  wire logic [7:0] SPAN_DUTY1,
    input  wire logic [7:0] SPAN_DUTY2,
    input  wire logic [7:0] SPAN_DUTY3,
    output logic      [7:0] FAN_DRIVE_OUTPUT1,
    output logic      [7:0] FAN_DRIVE_OUTPUT2,
    output logic      [7:0] FAN_DRIVE_OUTPUT3,
    output logic            OVERTEMP_SIGNAL_OUT,
    output logic            OVERTEMP_SIGNAL_OE,
    output logic            LOGIC_TREE_TEST,
    output logic            FULL_SPEED_FORCED
);
    // ****************************************
    // Parameter check
    // ****************************************
    if (NUM_CHANNELS != 3) begin : g_bad_channels
        $error("Bank serves exactly three temperature channels");
    end
    // Trio decode indexes by distance from the first offset of each trio
    if ((`OFS_OUT3_MIN_DUTY - `OFS_OUT1_MIN_DUTY != 8'h02)
        || (`OFS_REMOTE2_START - `OFS_REMOTE1_START != 8'h02)
        || (`OFS_REMOTE2_CRIT - `OFS_REMOTE1_CRIT != 8'h02)) begin : g_bad_map
        $error("Register trios must sit at three consecutive offsets");
    end

    // ****************************************
    // Register storage
    // ****************************************
    logic [7:0] min_duty_q   [3];
    logic [7:0] min_duty_d   [3];
    logic [7:0] start_q      [3];
    logic [7:0] start_d      [3];
    logic [7:0] crit_q       [3];
    logic [7:0] crit_d       [3];
    logic [7:0] hyst_r1l_q,  hyst_r1l_d;
    logic [7:0] hyst_r2_q,   hyst_r2_d;
    logic       test_q,      test_d;
    logic [7:0] off_r1_q,    off_r1_d;
    logic [7:0] off_l_q,     off_l_d;
    logic [7:0] rdata_q,     rdata_d;
    logic       wr_ok;

    function automatic logic [1:0] chan_of(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] diff;
        diff = addr - base;
        chan_of = diff[1:0];
    endfunction : chan_of

    function automatic logic in_trio(input logic [7:0] addr, input logic [7:0] base);
        in_trio = (addr >= base) && (addr <= base + 8'h02);
    endfunction : in_trio

    always_comb begin
        wr_ok      = REG_WR && !CONFIG_LOCK;
        min_duty_d = min_duty_q;
        start_d    = start_q;
        crit_d     = crit_q;
        hyst_r1l_d = hyst_r1l_q;
        hyst_r2_d  = hyst_r2_q;
        test_d     = test_q;
        off_r1_d   = off_r1_q;
        off_l_d    = off_l_q;
        if (wr_ok) begin
            if (in_trio(REG_ADDR, `OFS_OUT1_MIN_DUTY)) begin
                if (!AUTO_MODE)
                    min_duty_d[chan_of(REG_ADDR, `OFS_OUT1_MIN_DUTY)] = REG_WDATA;
            end else if (in_trio(REG_ADDR, `OFS_REMOTE1_START)) begin
                start_d[chan_of(REG_ADDR, `OFS_REMOTE1_START)] = REG_WDATA;
            end else if (in_trio(REG_ADDR, `OFS_REMOTE1_CRIT)) begin
                crit_d[chan_of(REG_ADDR, `OFS_REMOTE1_CRIT)] = REG_WDATA;
            end else if (REG_ADDR == `OFS_R1_LOCAL_HYST) begin
                hyst_r1l_d = REG_WDATA;
            end else if (REG_ADDR == `OFS_REMOTE2_HYST) begin
                hyst_r2_d = {REG_WDATA[7:4], 4'h0};
            end else if (REG_ADDR == `OFS_TEST_ENABLE) begin
                test_d = REG_WDATA[`TEST_BIT_POS];
            end else if (REG_ADDR == `OFS_REMOTE1_OFFSET) begin
                off_r1_d = REG_WDATA;
            end else if (REG_ADDR == `OFS_LOCAL_OFFSET) begin
                off_l_d = REG_WDATA;
            end
        end
    end

    // ****************************************
    // Read-back
    // ****************************************
    // Read mux; unmapped offsets read zero
    always_comb begin
        if (in_trio(REG_ADDR, `OFS_OUT1_MIN_DUTY))
            rdata_d = min_duty_q[chan_of(REG_ADDR, `OFS_OUT1_MIN_DUTY)];
        else if (in_trio(REG_ADDR, `OFS_REMOTE1_START))
            rdata_d = start_q[chan_of(REG_ADDR, `OFS_REMOTE1_START)];
        else if (in_trio(REG_ADDR, `OFS_REMOTE1_CRIT))
            rdata_d = crit_q[chan_of(REG_ADDR, `OFS_REMOTE1_CRIT)];
        else if (REG_ADDR == `OFS_R1_LOCAL_HYST)
            rdata_d = hyst_r1l_q;
        else if (REG_ADDR == `OFS_REMOTE2_HYST)
            rdata_d = hyst_r2_q;
        else if (REG_ADDR == `OFS_TEST_ENABLE)
            rdata_d = {7'h00, test_q};
        else if (REG_ADDR == `OFS_REMOTE1_OFFSET)
            rdata_d = off_r1_q;
        else if (REG_ADDR == `OFS_LOCAL_OFFSET)
            rdata_d = off_l_q;
        else
            rdata_d = `RST_ZERO;
    end

    // Registered so a read answers one edge after the address is presented
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B)
            rdata_q <= `RST_ZERO;
        else
            rdata_q <= rdata_d;
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            for (int i = 0; i < 3; i++) begin
                min_duty_q[i] <= `RST_MIN_DUTY;
                start_q[i]    <= `RST_START_TEMP;
                crit_q[i]     <= `RST_CRIT_LIMIT;
            end
            hyst_r1l_q <= `RST_R1_LOCAL_HYST;
            hyst_r2_q  <= `RST_REMOTE2_HYST;
            test_q     <= 1'b0;
            off_r1_q   <= `RST_ZERO;
            off_l_q    <= `RST_ZERO;
        end else begin
            min_duty_q <= min_duty_d;
            start_q    <= start_d;
            crit_q     <= crit_d;
            hyst_r1l_q <= hyst_r1l_d;
            hyst_r2_q  <= hyst_r2_d;
            test_q     <= test_d;
            off_r1_q   <= off_r1_d;
            off_l_q    <= off_l_d;
        end
    end

    // ****************************************
    // Offset correction
    // ****************************************
    // Readings and limits are compared in quarter degrees so the 0.5 degree
    // offset step and the 0.25 degree pin margin both stay exact.
    logic [7:0]  raw_temp   [3];
    logic [7:0]  offset_val [3];
    logic [3:0]  hyst_val   [3];
    logic [2:0]  fan_on, crit_hot, pin_hot;
    logic        force_full;
    logic [7:0]  span_duty  [3];
    logic [7:0]  duty       [3];

    always_comb begin
        raw_temp[0]   = REMOTE1_TEMP;
        raw_temp[1]   = LOCAL_TEMP;
        raw_temp[2]   = REMOTE2_TEMP;
        offset_val[0] = off_r1_q;
        offset_val[1] = off_l_q;
        offset_val[2] = REMOTE2_OFFSET;
        hyst_val[0]   = hyst_r1l_q[`REMOTE1_HYST_LSB +: 4];
        hyst_val[1]   = hyst_r1l_q[`LOCAL_HYST_LSB +: 4];
        hyst_val[2]   = hyst_r2_q[`REMOTE2_HYST_LSB +: 4];
        span_duty[0]  = SPAN_DUTY1;
        span_duty[1]  = SPAN_DUTY2;
        span_duty[2]  = SPAN_DUTY3;
    end

    // ****************************************
    // Per-channel evaluation
    // ****************************************
    for (genvar c = 0; c < 3; c++) begin : g_chan
        chan_limit_if lim ();
        logic signed [11:0] sum;
        always_comb begin
            // Half-degree step becomes two quarter-degree steps
            sum = $signed({2'b00, raw_temp[c], 2'b00})
                + $signed({{3{offset_val[c][7]}}, offset_val[c], 1'b0});
            if (sum < 0)
                lim.temp_q2 = 10'h000;
            else if (sum > 12'sd1023)
                lim.temp_q2 = 10'h3ff;
            else
                lim.temp_q2 = sum[9:0];
        end
        assign lim.cfg    = '{start_temp: start_q[c], crit_limit: crit_q[c], hyst: hyst_val[c]};
        assign lim.sample = CONV_DONE;
        chan_limit_eval u_eval (
            .clk   (SYS_CLK),
            .rst_b (RST_B),
            .lim   (lim.chan)
        );
        assign fan_on[c]   = lim.fan_on;
        assign crit_hot[c] = lim.crit_hot;
        assign pin_hot[c]  = lim.pin_hot;
    end

    assign force_full = |crit_hot;

    // ****************************************
    // Output duty
    // ****************************************
    for (genvar o = 0; o < 3; o++) begin : g_out
        duty_shaper u_shape (
            .clk        (SYS_CLK),
            .rst_b      (RST_B),
            .min_duty   (min_duty_q[o]),
            .min_select (MINIMUM_SELECT[o]),
            .fan_on     (fan_on[o]),
            .span_duty  (span_duty[o]),
            .force_full (force_full),
            .duty       (duty[o])
        );
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign REG_RDATA           = rdata_q;
    assign FAN_DRIVE_OUTPUT1   = duty[0];
    assign FAN_DRIVE_OUTPUT2   = duty[1];
    assign FAN_DRIVE_OUTPUT3   = duty[2];
    // Open-drain style: only ever pulls low
    assign OVERTEMP_SIGNAL_OUT = 1'b0;
    assign OVERTEMP_SIGNAL_OE  = OVERTEMP_PIN_OUT_EN && (|pin_hot);
    assign LOGIC_TREE_TEST     = test_q;
    assign FULL_SPEED_FORCED   = force_full;
endmodule : fan_control_limit_registers
`default_nettype wire

//--- tb/fan_limits_assertions.sv
`default_nettype none
module fan_limits_assertions #(
    parameter int NUM_CHANNELS = 3
) (
    input wire logic       SYS_CLK,
    input wire logic       RST_B,
    input wire logic       REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic       CONFIG_LOCK,
    input wire logic       AUTO_MODE,
    input wire logic       CONV_DONE,
    input wire logic [7:0] FAN_DRIVE_OUTPUT1,
    input wire logic [7:0] FAN_DRIVE_OUTPUT2,
    input wire logic [7:0] FAN_DRIVE_OUTPUT3,
    input wire logic       OVERTEMP_SIGNAL_OUT,
    input wire logic       OVERTEMP_SIGNAL_OE,
    input wire logic       OVERTEMP_PIN_OUT_EN,
    input wire logic       LOGIC_TREE_TEST,
    input wire logic       FULL_SPEED_FORCED
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_B);
    // ****************************************
    // Write read-back, lock and auto-mode checks, then test bit, forced duty, pin and conversion checks
    // ****************************************
    sequence s_hold_addr;
        $stable(REG_ADDR) && !REG_WR;
    endsequence
    sequence s_open_wr;
        REG_WR && !CONFIG_LOCK && REG_ADDR >= 8'h67 && REG_ADDR <= 8'h6d;
    endsequence
    a_write_reads_back: assert property (s_open_wr ##1 s_hold_addr |=> REG_RDATA == $past(REG_WDATA, 2))
        else $error("register did not return written value");
    a_lock_keeps_value: assert property (REG_WR && CONFIG_LOCK ##1 s_hold_addr |=> $stable(REG_RDATA))
        else $error("locked write changed a register");
    a_auto_min_ro: assert property (REG_WR && AUTO_MODE && REG_ADDR >= 8'h64 && REG_ADDR <= 8'h66
        ##1 s_hold_addr |=> $stable(REG_RDATA))
        else $error("minimum duty changed in automatic mode");
    a_test_bit_follows: assert property (REG_WR && !CONFIG_LOCK && REG_ADDR == 8'h6f
        |=> LOGIC_TREE_TEST == |($past(REG_WDATA) & 8'h01))
        else $error("test mode output does not follow bit 0");
    a_reserved_zero: assert property ($past(REG_ADDR) == 8'h6f |-> REG_RDATA[7:1] == 7'h00)
        else $error("reserved test bits read nonzero");
    a_forced_full: assert property (FULL_SPEED_FORCED
        |=> FAN_DRIVE_OUTPUT1 == 8'hff && FAN_DRIVE_OUTPUT2 == 8'hff && FAN_DRIVE_OUTPUT3 == 8'hff)
        else $error("forced state without full duty");
    a_pin_drives_low: assert property (OVERTEMP_SIGNAL_OUT == 1'b0)
        else $error("overtemp pin driven high");
    // The pin may only pull low while enabled and while a channel holds the fail-safe
    a_pin_needs_hot: assert property (OVERTEMP_SIGNAL_OE |-> OVERTEMP_PIN_OUT_EN && FULL_SPEED_FORCED)
        else $error("overtemp pin asserted without enable or fail-safe");
    a_eval_on_conv: assert property ($changed(FULL_SPEED_FORCED) |-> $past(CONV_DONE))
        else $error("forced state changed without a conversion");
endmodule : fan_limits_assertions
bind fan_control_limit_registers fan_limits_assertions #(.NUM_CHANNELS(NUM_CHANNELS)) u_chk (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .CONFIG_LOCK(CONFIG_LOCK), .AUTO_MODE(AUTO_MODE), .CONV_DONE(CONV_DONE),
    .FAN_DRIVE_OUTPUT1(FAN_DRIVE_OUTPUT1), .FAN_DRIVE_OUTPUT2(FAN_DRIVE_OUTPUT2),
    .FAN_DRIVE_OUTPUT3(FAN_DRIVE_OUTPUT3), .OVERTEMP_SIGNAL_OUT(OVERTEMP_SIGNAL_OUT),
    .OVERTEMP_SIGNAL_OE(OVERTEMP_SIGNAL_OE), .OVERTEMP_PIN_OUT_EN(OVERTEMP_PIN_OUT_EN),
    .LOGIC_TREE_TEST(LOGIC_TREE_TEST), .FULL_SPEED_FORCED(FULL_SPEED_FORCED));
`default_nettype wire

//--- tb/fan_model.sv
`default_nettype none
module fan_model (
    input  wire logic       clk,
    input  wire logic [7:0] duty1,
    input  wire logic [7:0] duty2,
    input  wire logic [7:0] duty3,
    output logic      [2:0] spinning
);
    timeunit 1ns;
    timeprecision 1ns;
    // A fan stops only at a zero code; it lags its drive by one clock
    always_ff @(posedge clk) begin
        spinning <= {duty3 != 8'h00, duty2 != 8'h00, duty1 != 8'h00};
    end
endmodule : fan_model
`default_nettype wire

//--- tb/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, rst_b, wr, lock, auto, pin_en, conv, ote, oout, ltt, forced;
    logic [7:0] addr, wdata, rdata, t1, tl, t2, span, d1, d2, d3, off2;
    logic [2:0] sel, spin;
    int         fails, checks_done, cycles;
    // Rows: address, write data, reset value, value read after the write
    logic [31:0] rows [16] = '{32'h64408040, 32'h65ff80ff, 32'h66008000, 32'h67509a50,
        32'h68509a50, 32'h69509a50, 32'h6a58a458, 32'h6b80a480, 32'h6c70a470, 32'h6d444444,
        32'h6e4f4040, 32'h6f010001, 32'h70040004, 32'h71000000, 32'h72550000, 32'h63120000};
    fan_control_limit_registers dut (
        .SYS_CLK(clk), .RST_B(rst_b), .REG_WR(wr), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .CONFIG_LOCK(lock), .AUTO_MODE(auto), .OVERTEMP_PIN_OUT_EN(pin_en), .MINIMUM_SELECT(sel),
        .CONV_DONE(conv), .REMOTE1_TEMP(t1), .LOCAL_TEMP(tl), .REMOTE2_TEMP(t2), .REMOTE2_OFFSET(off2),
        .SPAN_DUTY1(span), .SPAN_DUTY2(span), .SPAN_DUTY3(span), .FAN_DRIVE_OUTPUT1(d1),
        .FAN_DRIVE_OUTPUT2(d2), .FAN_DRIVE_OUTPUT3(d3), .OVERTEMP_SIGNAL_OUT(oout),
        .OVERTEMP_SIGNAL_OE(ote), .LOGIC_TREE_TEST(ltt), .FULL_SPEED_FORCED(forced));
    fan_model u_fans (.clk(clk), .duty1(d1), .duty2(d2), .duty3(d3), .spinning(spin));
    // ****************************************
    // Bus cycles and comparisons
    // ****************************************
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr8
    task automatic rd8(input logic [7:0] a);
        @(negedge clk);
        addr = a;
        @(negedge clk);
    endtask : rd8
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check8
    task automatic check1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check1
    // Evaluation happens only on the conversion pulse, so hold readings around it
    task automatic conv3(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        @(negedge clk);
        t1 = a;
        tl = b;
        t2 = c;
        conv = 1'b1;
        @(negedge clk);
        conv = 1'b0;
        repeat (3) @(negedge clk);
    endtask : conv3
    task automatic duty3(input logic [7:0] e1, input logic [7:0] e2, input logic [7:0] e3);
        check8(d1, e1);
        check8(d2, e2);
        check8(d3, e3);
    endtask : duty3
    task automatic stop_test;
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        {rst_b, wr, lock, auto, conv, addr, wdata, span, sel, off2} = '0;
        {pin_en, t1, tl, t2} = {1'b1, 24'h303030};
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        // Only bit 0 of the test register is ever written
        for (int i = 0; i < 16; i++) begin
            rd8(rows[i][31:24]);
            check8(rdata, rows[i][15:8]);
            wr8(rows[i][31:24], rows[i][23:16]);
            rd8(rows[i][31:24]);
            check8(rdata, rows[i][7:0]);
        end
        check1(ltt, 1'b1);
        wr8(8'h6f, 8'h00);
        check1(ltt, 1'b0);
        conv3(8'h30, 8'h30, 8'h30);
        duty3(8'h00, 8'h00, 8'h00);
        span = 8'h20;
        conv3(8'h51, 8'h51, 8'h51);
        duty3(8'h40, 8'hff, 8'h20);
        span = 8'h00;
        conv3(8'h4d, 8'h4d, 8'h4d);
        duty3(8'h40, 8'hff, 8'h00);
        sel = 3'b010;
        conv3(8'h4a, 8'h4c, 8'h4c);
        duty3(8'h00, 8'hff, 8'h00);
        check8({5'h00, spin}, 8'h02);
        conv3(8'h57, 8'h30, 8'h30);
        duty3(8'hff, 8'hff, 8'hff);
        check1(ote, 1'b1);
        check1(oout, 1'b0);
        conv3(8'h53, 8'h30, 8'h30);
        check1(forced, 1'b1);
        conv3(8'h51, 8'h30, 8'h30);
        check1(forced, 1'b0);
        pin_en = 1'b0;
        conv3(8'h30, 8'h90, 8'h30);
        check1(forced, 1'b0);
        // A negative offset of two degrees keeps remote 2 under its limit
        off2 = 8'hfc;
        conv3(8'h30, 8'h30, 8'h71);
        check1(forced, 1'b0);
        off2 = 8'h00;
        conv3(8'h30, 8'h30, 8'h71);
        check1(forced, 1'b1);
        check1(ote, 1'b0);
        lock = 1'b1;
        wr8(8'h67, 8'h11);
        rd8(8'h67);
        check8(rdata, 8'h50);
        lock = 1'b0;
        auto = 1'b1;
        wr8(8'h64, 8'h99);
        rd8(8'h64);
        check8(rdata, 8'h40);
        wr8(8'h6a, 8'h5a);
        rd8(8'h6a);
        check8(rdata, 8'h5a);
        auto = 1'b0;
        // A reset while the fail-safe holds must drop everything at once
        rst_b = 1'b0;
        @(negedge clk);
        check1(forced, 1'b0);
        duty3(8'h00, 8'h00, 8'h00);
        rst_b = 1'b1;
        rd8(8'h67);
        check8(rdata, 8'h9a);
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
